//--- hdl/jam_pkg.sv
// constants, jam codes and timing for the paper jam monitor
package jam_pkg;
  localparam int n_jam = 15;
  localparam int cnt_w = 24;
  // jam flag bit positions
  localparam int j_path_remain = 0;
  localparam int j_exit_remain = 1;
  localparam int j_entr_noarr = 2;
  localparam int j_entr_stat = 3;
  localparam int j_cover_open = 4;
  localparam int j_staple = 5;
  localparam int j_stack_exit = 6;
  localparam int j_mid_noarr = 7;
  localparam int j_mid_stat = 8;
  localparam int j_sub_noarr = 9;
  localparam int j_sub_stat = 10;
  localparam int j_sub_remain = 11;
  localparam int j_punch = 12;
  localparam int j_staple_slide = 13;
  localparam int j_exit_shift = 14;
  // diagnostic codes, one per flag; arbitrary values
  localparam logic [7:0] code_base = 8'h40;
  localparam logic [7:0] code_none = 8'h00;
  // thresholds: times in microseconds, counts in motor pulses
  localparam int clk_mhz = 100;
  // short timeouts keep every timer reachable within a bounded run
  localparam int entr_timeout_us = 20;
  localparam int clinch_timeout_us = 10;
  localparam int sub_run_us = 20;
  localparam logic [cnt_w-1:0] entr_timeout_cyc = cnt_w'(entr_timeout_us * clk_mhz);
  localparam logic [cnt_w-1:0] clinch_timeout_cyc = cnt_w'(clinch_timeout_us * clk_mhz);
  localparam logic [cnt_w-1:0] sub_run_cyc = cnt_w'(sub_run_us * clk_mhz);
  localparam logic [cnt_w-1:0] entr_stat_pulses = 24'h000200;
  localparam logic [cnt_w-1:0] mid_noarr_pulses = 24'h000300;
  localparam logic [cnt_w-1:0] mid_stat_pulses = 24'h000200;
  localparam logic [cnt_w-1:0] sub_stat_pulses = 24'h000200;
  localparam logic [cnt_w-1:0] stack_exit_pulses = 24'h000400;
  localparam int reset_val = 0;
endpackage

//--- hdl/jam_watch.sv
// watchdog: counts while armed and flags when the threshold is reached
`timescale 1ns/1ns
`default_nettype none
module jam_watch (
  input wire logic mclk, // system clock
  input wire logic rst, // async reset, high
  input wire logic ce, // clock enable
  input wire logic arm, // start watching (pulse)
  input wire logic done, // watched condition resolved (level)
  input wire logic tick, // count qualifier: pulse or cycle
  input wire logic [23:0] limit, // threshold
  output logic expired // one-cycle pulse on timeout
);
  logic active;
  logic next_active;
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic next_expired;

  always_comb begin
    next_active = active;
    next_cnt = cnt;
    next_expired = 1'b0;
    if (arm) begin
      next_active = 1'b1;
      next_cnt = 24'h000000;
    end else if (active) begin
      if (done) begin
        next_active = 1'b0;
      end else if (cnt >= limit) begin
        next_expired = 1'b1;
        next_active = 1'b0;
      end else if (tick) begin
        next_cnt = cnt + 24'h000001;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      active <= 1'b0;
      cnt <= 24'h000000;
      expired <= 1'b0;
    end else if (ce) begin
      active <= next_active;
      cnt <= next_cnt;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

//--- hdl/paper_jam_monitor.sv
// jam detection monitor for a sheet finisher with optional punch unit
// How it works
// - entrance or middle sensor holding paper at power-on or cover close flags path jam
// - with punch fitted, punch paper sensor at power-on or cover close also flags it
// - finishing tray sensor holding paper at power-on flags exit remaining jam
// - entrance sensor not seeing paper within timeout after host feed flags jam
// - entrance sensor still covered after first motor pulses flags stationary jam
// - front cover or sub-path guide open while operating flags cover jam
// - with punch fitted, punch connection open also flags cover jam
// - improper clinch sensor blocking stapling flags stapling jam
// - clinch not reopening within timeout after closing during stapling flags stapling jam
// - clinch must read open during reverse rotation, else stapling jam
// - staple start sensor not ready during ejection flags stapling jam
// - tray still holding stack after exit motor pulses flags stack exit jam
// - middle sensor not reached after entrance detect plus first motor pulses
// - middle sensor still covered after second motor pulses flags stationary jam
// - sub-path not reached after entrance detect and both motors ran set time
// - sub-path still covered after second motor pulses flags stationary jam
// - sub-path paper at power-on or front cover close flags remaining jam
// - punch shaft away from home after punching flags punching jam
// - punch slide motor error during feeding flags punching jam
// - staple slide motor error during feeding flags its own error
// - exit roller shift motor error during feeding flags its own error
// - the lowest-numbered latched jam is reported to the host as a diagnostic code
// - punch shaft home sensor off means puncher is at home
`timescale 1ns/1ns
`default_nettype none
module paper_jam_monitor (
  input wire logic mclk, // 100 MHz system clock
  input wire logic rst, // async reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic entrance_path_sensor, // paper present
  input wire logic middle_path_sensor, // paper present
  input wire logic punch_paper_detect_sensor, // paper present
  input wire logic finishing_tray_sensor, // stack present
  input wire logic sub_path_sensor, // paper present
  input wire logic sub_path_open_sensor, // guide open
  input wire logic front_cover_switch, // cover open
  input wire logic jam_cover_closed, // jam access cover closed
  input wire logic punch_fitted, // punch unit installed
  input wire logic punch_connect_open, // punch connection reports open
  input wire logic improper_clinch_sensor, // stapling impossible
  input wire logic clinch_home_sensor, // high = clinch closed
  input wire logic stapling, // stapling stroke in progress
  input wire logic clinch_reverse, // reverse rotation after stapling
  input wire logic staple_start_position_sensor, // staple ready
  input wire logic staple_eject, // staple ejection in progress
  input wire logic stack_exit_start, // stack exit begun
  input wire logic stack_exit_motor_pulse, // exit-direction step
  input wire logic first_transport_motor_pulse, // step
  input wire logic second_transport_motor_pulse, // step
  input wire logic transport_running, // both transport motors on
  input wire logic punch_done, // punching finished
  input wire logic punch_shaft_home_sensor, // high = away from home
  input wire logic punch_slide_motor_err, // motor error
  input wire logic staple_slide_motor_err, // motor error
  input wire logic exit_roller_shift_motor_err, // motor error
  input wire logic operating, // finisher operating / feeding
  input wire logic host_feed, // feed signal from host (same clock)
  input wire logic host_clear, // clear all jam flags (same clock)
  output logic [14:0] jam_flags, // latched jam flags
  output logic [7:0] diag_code, // diagnostic code of lowest jam
  output logic diag_valid // a jam is reported
);
  import jam_pkg::*;

  localparam int n_in = 27;
  // bit positions of the pins inside the synchroniser, msb first
  // paper sensors
  localparam int i_entr = 26;
  localparam int i_mid = 25;
  localparam int i_pdet = 24;
  localparam int i_tray = 23;
  localparam int i_sub = 22;
  // covers and unit presence
  localparam int i_subopen = 21;
  localparam int i_front = 20;
  localparam int i_jcov = 19;
  localparam int i_pfit = 18;
  localparam int i_pcon = 17;
  // stapler
  localparam int i_imp = 16;
  localparam int i_clinch = 15;
  localparam int i_stapling = 14;
  localparam int i_rev = 13;
  localparam int i_sready = 12;
  localparam int i_eject = 11;
  // motors and phases
  localparam int i_xstart = 10;
  localparam int i_xpulse = 9;
  localparam int i_m1 = 8;
  localparam int i_m2 = 7;
  localparam int i_run = 6;
  localparam int i_pdone = 5;
  localparam int i_pshaft = 4;
  // motor errors and operating
  localparam int i_perr = 3;
  localparam int i_serr = 2;
  localparam int i_xerr = 1;
  localparam int i_oper = 0;

  wire [n_in-1:0] raw;
  logic [n_in-1:0] sync1;
  logic [n_in-1:0] sync2;
  logic [n_in-1:0] prev;

  // one pin per named bit, so a reordered list cannot swap sensors
  // paper sensors
  assign raw[i_entr] = entrance_path_sensor;
  assign raw[i_mid] = middle_path_sensor;
  assign raw[i_pdet] = punch_paper_detect_sensor;
  assign raw[i_tray] = finishing_tray_sensor;
  assign raw[i_sub] = sub_path_sensor;
  // covers and unit presence
  assign raw[i_subopen] = sub_path_open_sensor;
  assign raw[i_front] = front_cover_switch;
  assign raw[i_jcov] = jam_cover_closed;
  assign raw[i_pfit] = punch_fitted;
  assign raw[i_pcon] = punch_connect_open;
  // stapler
  assign raw[i_imp] = improper_clinch_sensor;
  assign raw[i_clinch] = clinch_home_sensor;
  assign raw[i_stapling] = stapling;
  assign raw[i_rev] = clinch_reverse;
  assign raw[i_sready] = staple_start_position_sensor;
  assign raw[i_eject] = staple_eject;
  // motors and phases
  assign raw[i_xstart] = stack_exit_start;
  assign raw[i_xpulse] = stack_exit_motor_pulse;
  assign raw[i_m1] = first_transport_motor_pulse;
  assign raw[i_m2] = second_transport_motor_pulse;
  assign raw[i_run] = transport_running;
  assign raw[i_pdone] = punch_done;
  assign raw[i_pshaft] = punch_shaft_home_sensor;
  // motor errors and operating
  assign raw[i_perr] = punch_slide_motor_err;
  assign raw[i_serr] = staple_slide_motor_err;
  assign raw[i_xerr] = exit_roller_shift_motor_err;
  assign raw[i_oper] = operating;

  // pins come from outside the clock domain
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else if (ce) begin
      sync1 <= raw;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  logic s_entr, s_mid, s_pdet, s_tray, s_sub, s_subopen, s_front, s_jcov, s_pfit, s_pcon;
  logic s_imp, s_clinch, s_stapling, s_rev, s_sready, s_eject, s_xstart, s_xpulse;
  logic s_m1, s_m2, s_run, s_pdone, s_pshaft, s_perr, s_serr, s_xerr, s_oper;
  assign {s_entr, s_mid, s_pdet, s_tray, s_sub, s_subopen, s_front, s_jcov, s_pfit, s_pcon,
    s_imp, s_clinch, s_stapling, s_rev, s_sready, s_eject, s_xstart, s_xpulse, s_m1, s_m2,
    s_run, s_pdone, s_pshaft, s_perr, s_serr, s_xerr, s_oper} = sync2;

  function automatic logic rise(input int idx);
    rise = sync2[idx] && !prev[idx];
  endfunction

  // power-on check: wait for synchroniser to fill, then sample once
  logic [1:0] pwr_cnt;
  logic [1:0] next_pwr_cnt;
  logic pwr_check;
  assign pwr_check = (pwr_cnt == 2'h2);

  always_comb begin
    next_pwr_cnt = pwr_cnt;
    if (pwr_cnt != 2'h3) begin
      next_pwr_cnt = pwr_cnt + 2'h1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_cnt <= 2'h0;
    end else if (ce) begin
      pwr_cnt <= next_pwr_cnt;
    end
  end

  logic jcov_close;
  logic front_close;
  logic m1_tick, m2_tick, x_tick;
  assign jcov_close = rise(i_jcov);
  assign front_close = !s_front && prev[i_front];
  assign m1_tick = rise(i_m1);
  assign m2_tick = rise(i_m2);
  assign x_tick = rise(i_xpulse);

  // watchdog bank
  localparam int n_w = 8;
  logic [n_w-1:0] w_arm, w_done, w_tick, w_exp;
  logic [23:0] w_limit [n_w];

  assign w_arm[0] = host_feed;
  assign w_done[0] = s_entr;
  assign w_tick[0] = 1'b1;
  assign w_limit[0] = entr_timeout_cyc;
  assign w_arm[1] = rise(i_entr);
  assign w_done[1] = !s_entr;
  assign w_tick[1] = m1_tick;
  assign w_limit[1] = entr_stat_pulses;
  assign w_arm[2] = rise(i_entr);
  assign w_done[2] = s_mid;
  assign w_tick[2] = m1_tick;
  assign w_limit[2] = mid_noarr_pulses;
  assign w_arm[3] = rise(i_mid);
  assign w_done[3] = !s_mid;
  assign w_tick[3] = m2_tick;
  assign w_limit[3] = mid_stat_pulses;
  assign w_arm[4] = rise(i_entr);
  assign w_done[4] = s_sub;
  assign w_tick[4] = s_run;
  assign w_limit[4] = sub_run_cyc;
  assign w_arm[5] = rise(i_sub);
  assign w_done[5] = !s_sub;
  assign w_tick[5] = m2_tick;
  assign w_limit[5] = sub_stat_pulses;
  assign w_arm[6] = rise(i_xstart);
  assign w_done[6] = !s_tray;
  assign w_tick[6] = x_tick;
  assign w_limit[6] = stack_exit_pulses;
  // clinch closed during stapling must reopen in time
  assign w_arm[7] = rise(i_clinch) && s_stapling;
  assign w_done[7] = !s_clinch;
  assign w_tick[7] = 1'b1;
  assign w_limit[7] = clinch_timeout_cyc;

  genvar g;
  generate
    for (g = 0; g < n_w; g++) begin : g_watch
      jam_watch u_watch (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .arm(w_arm[g]),
        .done(w_done[g]),
        .tick(w_tick[g]),
        .limit(w_limit[g]),
        .expired(w_exp[g])
      );
    end
  endgenerate

  // event terms, one per flag
  logic [n_jam-1:0] ev;
  always_comb begin
    ev = '0;
    ev[j_path_remain] = ((pwr_check || jcov_close) && (s_entr || s_mid))
      || ((pwr_check || jcov_close) && s_pfit && s_pdet);
    ev[j_exit_remain] = pwr_check && s_tray;
    ev[j_entr_noarr] = w_exp[0];
    ev[j_entr_stat] = w_exp[1];
    ev[j_cover_open] = (s_oper && (s_front || s_subopen))
      || (s_pfit && s_pcon);
    ev[j_staple] = s_imp
      || w_exp[7]
      || (s_rev && s_clinch)
      || (s_eject && !s_sready);
    ev[j_stack_exit] = w_exp[6];
    ev[j_mid_noarr] = w_exp[2];
    ev[j_mid_stat] = w_exp[3];
    ev[j_sub_noarr] = w_exp[4];
    ev[j_sub_stat] = w_exp[5];
    ev[j_sub_remain] = (pwr_check || front_close) && s_sub;
    // sensor low means home, so high after punching is an error
    ev[j_punch] = (s_pfit && rise(i_pdone) && s_pshaft)
      || (s_pfit && s_oper && s_perr);
    ev[j_staple_slide] = s_oper && s_serr;
    ev[j_exit_shift] = s_oper && s_xerr;
  end

  // flags latch; a new event wins over a host clear
  logic [n_jam-1:0] next_flags;
  logic [7:0] next_code;
  logic next_valid;

  always_comb begin
    next_flags = host_clear ? ev : (jam_flags | ev);
    next_code = code_none;
    next_valid = |next_flags;
    for (int k = n_jam - 1; k >= 0; k--) begin
      if (next_flags[k]) begin
        next_code = code_base + 8'(k);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      jam_flags <= '0;
      diag_code <= code_none;
      diag_valid <= 1'b0;
    end else if (ce) begin
      jam_flags <= next_flags;
      diag_code <= next_code;
      diag_valid <= next_valid;
    end
  end
endmodule
`default_nettype wire

//--- verif/paper_jam_monitor_properties.sv
// port checker for the paper jam monitor
`timescale 1ns/1ns
`default_nettype none
module jam_monitor_props (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic ce, // enable
  input wire logic operating, // feeding
  input wire logic front_cover_switch, // open
  input wire logic punch_fitted, // fitted
  input wire logic punch_connect_open, // open
  input wire logic improper_clinch_sensor, // blocked
  input wire logic punch_slide_motor_err, // err
  input wire logic staple_slide_motor_err, // err
  input wire logic exit_roller_shift_motor_err, // err
  input wire logic host_clear, // clear
  input wire logic [14:0] jam_flags, // flags
  input wire logic [7:0] diag_code, // code
  input wire logic diag_valid // any
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // five samples leave room for the two-flop synchroniser
  property p_cov; (ce && operating && front_cover_switch)[*5] |=> jam_flags[4]; endproperty
  a_cov: assert property (p_cov) else $error("cover jam missed");
  property p_pco; (ce && punch_fitted && punch_connect_open)[*5] |=> jam_flags[4]; endproperty
  a_pco: assert property (p_pco) else $error("punch link jam missed");
  property p_cli; (ce && improper_clinch_sensor)[*5] |=> jam_flags[5]; endproperty
  a_cli: assert property (p_cli) else $error("clinch jam missed");
  property p_e12;
    (ce && operating && punch_fitted && punch_slide_motor_err)[*5] |=> jam_flags[12];
  endproperty
  a_e12: assert property (p_e12) else $error("punch slide err missed");
  property p_e13; (ce && operating && staple_slide_motor_err)[*5] |=> jam_flags[13]; endproperty
  a_e13: assert property (p_e13) else $error("staple slide err missed");
  property p_e14; (ce && operating && exit_roller_shift_motor_err)[*5] |=> jam_flags[14];
  endproperty
  a_e14: assert property (p_e14) else $error("shift motor err missed");
  property p_vld; diag_valid == (jam_flags != 15'h0000); endproperty
  a_vld: assert property (p_vld) else $error("valid mismatch");
  property p_cod; jam_flags[0] |-> diag_code == 8'h40; endproperty
  a_cod: assert property (p_cod) else $error("code mismatch");
  property p_hld; (|($past(jam_flags) & ~jam_flags)) |-> $past(host_clear); endproperty
  a_hld: assert property (p_hld) else $error("flag dropped unasked");
  property p_frz; !ce |=> $stable(jam_flags); endproperty
  a_frz: assert property (p_frz) else $error("flags moved while frozen");
  c_cov: cover property ($rose(jam_flags[4]));
  c_stat: cover property ($rose(jam_flags[3]));
  c_clr: cover property (host_clear && diag_valid);
endmodule
bind paper_jam_monitor jam_monitor_props u_props (.*);
`default_nettype wire

//--- verif/host_model.sv
// host side: passes clear requests and keeps the code on display
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic mclk, // clock
  input wire logic rst, // reset
  input wire logic diag_valid, // jam shown
  input wire logic [7:0] diag_code, // jam code
  input wire logic clr_req, // operator clears
  output logic host_clear, // to monitor
  output logic [7:0] shown_code // on the panel
);
  assign host_clear = clr_req;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) shown_code <= 8'h00;
    else shown_code <= diag_valid ? diag_code : 8'h00;
  end
endmodule
`default_nettype wire

//--- verif/paper_jam_monitor_tb.sv
// self-checking bench for the paper jam monitor
`timescale 1ns/1ns
`default_nettype none
module paper_jam_monitor_tb;
  import jam_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, operating = 1'b1, punch_fitted = 1'b1;
  // paper held through reset for the power-on check
  logic entrance_path_sensor = 1'b1, finishing_tray_sensor = 1'b1, sub_path_sensor = 1'b1;
  logic staple_start_position_sensor = 1'b1, host_feed = 1'b0, stapling = 1'b0;
  logic transport_running = 1'b0, clr_req = 1'b0, host_clear, diag_valid;
  logic middle_path_sensor = 1'b0, punch_paper_detect_sensor = 1'b0, punch_done = 1'b0;
  logic sub_path_open_sensor = 1'b0, front_cover_switch = 1'b0, jam_cover_closed = 1'b0;
  logic punch_connect_open = 1'b0, improper_clinch_sensor = 1'b0, clinch_home_sensor = 1'b0;
  logic clinch_reverse = 1'b0, staple_eject = 1'b0, stack_exit_start = 1'b0;
  logic stack_exit_motor_pulse = 1'b0, first_transport_motor_pulse = 1'b0;
  logic second_transport_motor_pulse = 1'b0, punch_shaft_home_sensor = 1'b0;
  logic punch_slide_motor_err = 1'b0, staple_slide_motor_err = 1'b0;
  logic exit_roller_shift_motor_err = 1'b0;
  logic [14:0] jam_flags;
  logic [7:0] diag_code, shown_code;
  int err_count = 0, n_checks = 0;
  int bits[12] = '{4, 4, 4, 5, 5, 5, 12, 13, 14, 0, 0, 12};
  paper_jam_monitor DUT (.*);
  host_model HM (.*);
  always #5 mclk = ~mclk;
  function automatic logic [7:0] code_of(input logic [14:0] f);
    code_of = code_none;
    for (int i = 14; i >= 0; i--) begin
      if (f[i]) code_of = code_base + 8'(i);
    end
  endfunction
  task automatic cmp_f(input logic [14:0] got, input logic [14:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_c(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [14:0] ef);
    repeat (6) @(negedge mclk);
    cmp_f(jam_flags, ef);
    cmp_f({14'h0000, diag_valid}, {14'h0000, ef != 15'h0000});
    cmp_c(diag_code, code_of(ef));
    cmp_c(shown_code, code_of(ef));
  endtask
  task automatic idle();
    {front_cover_switch, sub_path_open_sensor, punch_connect_open, improper_clinch_sensor} = '0;
    {clinch_reverse, clinch_home_sensor, staple_eject, punch_slide_motor_err} = '0;
    {staple_slide_motor_err, exit_roller_shift_motor_err, middle_path_sensor} = '0;
    {punch_paper_detect_sensor, jam_cover_closed, punch_done, punch_shaft_home_sensor} = '0;
    {entrance_path_sensor, finishing_tray_sensor, sub_path_sensor, stack_exit_start} = '0;
    staple_start_position_sensor = 1'b1;
  endtask
  // causes are released first: a clear loses to a live event
  task automatic finisher_controller_board(input logic [14:0] ef);
    idle();
    chk(ef);
    clr_req = 1'b1;
    @(negedge mclk);
    clr_req = 1'b0;
    chk(15'h0000);
  endtask
  task automatic pul(ref logic s, input int n);
    repeat (n) begin
      s = 1'b1;
      @(negedge mclk);
      s = 1'b0;
      @(negedge mclk);
    end
  endtask
  task automatic t_count(ref logic s, input int n, input logic [14:0] ef);
    repeat (4) @(negedge mclk);
    pul(s, n - 1);
    chk(15'h0000);
    pul(s, 1);
    finisher_controller_board(ef);
  endtask
  task automatic t_events();
    for (int i = 0; i < 12; i++) begin
      case (i)
        0: begin
          ce = 1'b0;
          front_cover_switch = 1'b1;
          repeat (6) @(negedge mclk);
          cmp_f(jam_flags, 15'h0000);
          ce = 1'b1;
        end
        1: sub_path_open_sensor = 1'b1;
        2: punch_connect_open = 1'b1;
        3: improper_clinch_sensor = 1'b1;
        4: {clinch_reverse, clinch_home_sensor} = 2'b11;
        5: {staple_eject, staple_start_position_sensor} = 2'b10;
        6: punch_slide_motor_err = 1'b1;
        7: staple_slide_motor_err = 1'b1;
        8: exit_roller_shift_motor_err = 1'b1;
        9: middle_path_sensor = 1'b1;
        10: punch_paper_detect_sensor = 1'b1;
        11: punch_shaft_home_sensor = 1'b1;
        default: idle();
      endcase
      repeat (4) @(negedge mclk);
      if (i == 9 || i == 10) jam_cover_closed = 1'b1;
      if (i == 11) punch_done = 1'b1;
      repeat (4) @(negedge mclk);
      finisher_controller_board(15'(1) << bits[i]);
    end
  endtask
  task automatic t_timers();
    host_feed = 1'b1;
    @(negedge mclk);
    host_feed = 1'b0;
    repeat (entr_timeout_cyc - 20) @(negedge mclk);
    chk(15'h0000);
    repeat (20) @(negedge mclk);
    finisher_controller_board(15'h0004);
    stapling = 1'b1;
    repeat (4) @(negedge mclk);
    clinch_home_sensor = 1'b1;
    repeat (clinch_timeout_cyc - 20) @(negedge mclk);
    chk(15'h0000);
    repeat (20) @(negedge mclk);
    stapling = 1'b0;
    finisher_controller_board(15'h0020);
    entrance_path_sensor = 1'b1;
    repeat (4) @(negedge mclk);
    pul(first_transport_motor_pulse, mid_noarr_pulses - 1);
    chk(15'h0008);
    pul(first_transport_motor_pulse, 1);
    finisher_controller_board(15'h0088);
    entrance_path_sensor = 1'b1;
    repeat (4) @(negedge mclk);
    transport_running = 1'b1;
    repeat (sub_run_cyc - 20) @(negedge mclk);
    chk(15'h0000);
    repeat (20) @(negedge mclk);
    transport_running = 1'b0;
    finisher_controller_board(15'h0200);
  endtask
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    finisher_controller_board(15'h0803);
    t_events();
    entrance_path_sensor = 1'b1;
    t_count(first_transport_motor_pulse, entr_stat_pulses, 15'h0008);
    {finishing_tray_sensor, stack_exit_start} = 2'b11;
    t_count(stack_exit_motor_pulse, stack_exit_pulses, 15'h0040);
    {middle_path_sensor, sub_path_sensor} = 2'b11;
    t_count(second_transport_motor_pulse, mid_stat_pulses, 15'h0500);
    t_timers();
    wrap_up();
  end
  // whole run is near 11k cycles; over four times that means a hang
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
